// *** lcdha_pkg.sv ***
package lcdha_pkg;
  localparam logic [7:0] LCDHA_RESET_CODE = 8'h20;
  localparam int LCDHA_CLK_MHZ = 200;
  localparam int LCDHA_EXEC_US = 72;
  localparam int LCDHA_CLEAR_US = 1600;
  localparam int LCDHA_EXEC_CYC = LCDHA_EXEC_US * LCDHA_CLK_MHZ;
  localparam int LCDHA_CLEAR_CYC = LCDHA_CLEAR_US * LCDHA_CLK_MHZ;
  localparam int LCDHA_ADDR_W = 7;
  localparam logic [6:0] LCDHA_AC_RESET = 7'h00;
  localparam logic [3:0] LCDHA_GX_LAST = 4'hf;
  localparam logic [7:0] LCDHA_HALF_LO = 8'h02;
  localparam logic [7:0] LCDHA_HALF_HI = 8'h7f;
  localparam logic [7:0] LCDHA_FULL_LEAD = 8'ha1;
  localparam logic [15:0] LCDHA_BIG_LO = 16'ha140;
  localparam logic [15:0] LCDHA_BIG_HI = 16'hd75f;
  localparam logic [15:0] LCDHA_GB_LO = 16'ha1a0;
  localparam logic [15:0] LCDHA_GB_HI = 16'hf7ff;
  localparam logic [1:0] LCDHA_SHOWN_LINES = 2'h2;
  typedef enum logic [1:0] {
    LCDHA_KIND_NONE = 2'b00,
    LCDHA_KIND_HALF = 2'b01,
    LCDHA_KIND_USER = 2'b10,
    LCDHA_KIND_FULL = 2'b11
  } lcdha_kind_t;
  typedef enum logic [1:0] {
    LCDHA_MEM_CHAR = 2'b00,
    LCDHA_MEM_FONT = 2'b01,
    LCDHA_MEM_GFX = 2'b10
  } lcdha_mem_t;
  typedef enum logic [1:0] {
    LCDHA_GS_IDLE = 2'b00,
    LCDHA_GS_HORZ = 2'b01,
    LCDHA_GS_DATA = 2'b10
  } lcdha_gstate_t;
endpackage

// *** lcdha_mem.sv ***
`timescale 1ns/1ps
module lcdha_mem
  import lcdha_pkg::*;
#(
  parameter int ADDR_W = 7,
  parameter int DATA_W = 8
)
(
  input wire logic clock_in,
  input wire logic we_in,
  input wire logic [ADDR_W-1:0] waddr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  input wire logic [ADDR_W-1:0] raddr_in,
  output logic [DATA_W-1:0] rdata_out
);
  logic [DATA_W-1:0] store [0:(1<<ADDR_W)-1];
  always_ff @(posedge clock_in)
  begin
    if (we_in)
      store[waddr_in] <= wdata_in;
    rdata_out <= store[raddr_in];
  end
endmodule // lcdha_mem

// *** lcdha_core.sv ***
`timescale 1ns/1ps
// Operation
// RULE_01: bus_type_select high picks parallel bus, low picks clocked serial link.
// RULE_02: Function-set bus_width_bit picks 8-bit or 4-bit parallel width.
// RULE_03: register_select low and write load the instruction register.
// RULE_04: register_select low and read returns busy flag and address counter.
// RULE_05: register_select high writes or reads the data register.
// RULE_06: Enable pin is the parallel transfer strobe, active high.
// RULE_07: Serial link is write only, no read path.
// RULE_08: In serial mode register_select is an active-high chip select.
// RULE_09: Host keeps serial lines steady while chip select is low.
// RULE_10: Serial data is sampled on the host serial clock.
// RULE_11: Busy flag stays high during processing; instructions ignored meanwhile.
// RULE_12: Host checks busy flag low before each new instruction.
// RULE_13: Address counter steps by one after each memory access per entry mode.
// RULE_14: Status read drives address counter on data lines six to zero.
// RULE_15: Codes 02 to 7F hex each render one half-width character.
// RULE_16: Only codes 0000, 0002, 0004, 0006 hex select user fonts.
// RULE_17: Byte above A1 hex pairs with the next byte as full-width code.
// RULE_18: Host writes upper byte first, lower byte second.
// RULE_19: Full-width and user characters only start at a word boundary.
// RULE_20: Four lines are stored but only two are shown.
// RULE_21: Host sends graphic vertical address then horizontal address.
// RULE_22: Graphic horizontal address advances per 16-bit word, wraps at 0F.
// RULE_23: Host sends vertical, horizontal, upper data, lower data in order.
// RULE_24: 4-bit mode moves each byte as two nibbles, high nibble first.
// RULE_25: Active-low reset returns the controller to its reset state.
module lcdha_core
  import lcdha_pkg::*;
#(
  parameter int EXEC_CYC = LCDHA_EXEC_CYC,
  parameter int CLEAR_CYC = LCDHA_CLEAR_CYC
)
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic bus_type_select_in,
  input wire logic register_select_in,
  input wire logic rw_serial_data_in,
  input wire logic enable_serial_clock_in,
  input wire logic [7:0] db_in,
  output logic [7:0] db_out,
  output logic db_oe_out,
  output logic busy_flag_out,
  output logic [6:0] address_counter_out,
  output logic bus_width_bit_out,
  output logic [7:0] instruction_register_out,
  output logic [7:0] data_register_out,
  output logic [1:0] char_kind_out,
  output logic [15:0] char_code_out,
  output logic [3:0] graphic_horz_out,
  output logic [6:0] graphic_vert_out,
  output logic [1:0] shown_lines_out
);
  function automatic lcdha_kind_t classify(input logic [15:0] w);
    if (w == 16'h0000 || w == 16'h0002 || w == 16'h0004 || w == 16'h0006)
      return LCDHA_KIND_USER; // see RULE_16
    if (w[15:8] >= LCDHA_FULL_LEAD &&
        ((w >= LCDHA_BIG_LO && w <= LCDHA_BIG_HI) || (w >= LCDHA_GB_LO && w <= LCDHA_GB_HI)))
      return LCDHA_KIND_FULL; // see RULE_17
    if (w[15:8] >= LCDHA_HALF_LO && w[15:8] <= LCDHA_HALF_HI)
      return LCDHA_KIND_HALF; // see RULE_15
    return LCDHA_KIND_NONE;
  endfunction

  // Pins come from the host's domain: two flops each before use
  logic [3:0] s1, s2;
  logic [7:0] d1, d2;
  always_ff @(posedge clock_in)
  begin
    s1 <= {bus_type_select_in, register_select_in, rw_serial_data_in, enable_serial_clock_in};
    s2 <= s1;
    d1 <= db_in;
    d2 <= d1;
  end
  wire par = s2[3]; // see RULE_01
  wire rs = s2[2];
  wire rw = s2[1];
  wire en = s2[0];
  logic en_q;
  always_ff @(posedge clock_in)
    en_q <= en;
  wire en_rise = en && !en_q;
  wire en_fall = !en && en_q;

  logic busy;
  logic width8;
  logic nib_half;
  logic [3:0] nib_hi;
  logic [6:0] ac;
  logic inc_dir;
  lcdha_mem_t target;
  lcdha_gstate_t gstate;
  logic [3:0] gx;
  logic [6:0] gy;
  logic g_second;
  logic [31:0] busy_cnt;
  logic [7:0] ir, dr;
  logic [7:0] ser_shift;
  logic [4:0] ser_cnt;
  logic [7:0] ser_byte;
  logic ser_rs;

  // Serial frame: 24 clocks; top bit of the first byte picks data or instruction
  wire ser_sel = !par && rs; // see RULE_08
  wire sclk_rise = ser_sel && en_rise; // see RULE_10
  wire ser_done = sclk_rise && ser_cnt == 5'd23;

  // Parallel byte assembly; 4-bit mode collects high nibble first
  wire par_strobe = par && en_fall; // see RULE_06
  wire byte_done = par_strobe && (width8 || nib_half); // see RULE_02
  wire [7:0] par_byte = width8 ? d2 : {nib_hi, d2[7:4]}; // see RULE_24

  wire wr_ins = (byte_done && !rs && !rw) || (ser_done && !ser_rs); // see RULE_03
  wire wr_dat = (byte_done && rs && !rw) || (ser_done && ser_rs); // see RULE_05
  wire rd_dat = byte_done && rs && rw;
  // Last shift is not yet in ser_shift when ser_done fires, so bits sit one place down
  wire [7:0] in_byte = par ? par_byte : {ser_byte[7:4], ser_shift[6:3]};
  wire accept_ins = wr_ins && !busy; // see RULE_11

  wire is_func = in_byte[7:5] == 3'b001;
  wire is_clear = in_byte == 8'h01;
  wire is_home = in_byte[7:1] == 7'h01;
  wire is_entry = in_byte[7:2] == 6'h01;
  wire is_font = in_byte[7:6] == 2'b01;
  wire is_char = in_byte[7] && target != LCDHA_MEM_GFX;
  wire is_gfx = in_byte[7] && target == LCDHA_MEM_GFX;
  wire mem_access = wr_dat || rd_dat;

  // Serial shift register; no read answer exists on this link
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in || !ser_sel)
    begin
      ser_cnt <= 5'd0;
      ser_shift <= 8'h00;
      ser_byte <= 8'h00;
      ser_rs <= 1'b0;
    end
    else if (sclk_rise)
    begin
      ser_shift <= {ser_shift[6:0], s2[1]};
      if (ser_cnt == 5'd0)
        ser_rs <= s2[1];
      ser_cnt <= (ser_cnt == 5'd23) ? 5'd0 : ser_cnt + 5'd1;
      if (ser_cnt == 5'd15)
        ser_byte <= {ser_shift[6:0], s2[1]};
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      nib_half <= 1'b0;
      nib_hi <= 4'h0;
    end
    else if (!width8 && par_strobe)
    begin
      nib_half <= !nib_half;
      nib_hi <= d2[7:4];
    end
  end

  // Busy timer; clear takes longer than other instructions
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      busy <= 1'b0;
      busy_cnt <= 32'd0;
    end
    else if (accept_ins || (mem_access && !busy))
    begin
      busy <= 1'b1;
      busy_cnt <= (accept_ins && is_clear) ? 32'(CLEAR_CYC - 1) : 32'(EXEC_CYC - 1);
    end
    else if (busy)
    begin
      if (busy_cnt == 32'd0)
        busy <= 1'b0; // see RULE_11
      else
        busy_cnt <= busy_cnt - 32'd1;
    end
  end

  // Instruction side effects and the address counter
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in) // see RULE_25
    begin
      width8 <= 1'b1;
      ac <= LCDHA_AC_RESET;
      inc_dir <= 1'b1;
      target <= LCDHA_MEM_CHAR;
      gstate <= LCDHA_GS_IDLE;
      gx <= 4'h0;
      gy <= 7'h00;
      g_second <= 1'b0;
      ir <= 8'h00;
      dr <= 8'h00;
    end
    else if (accept_ins)
    begin
      ir <= in_byte;
      if (is_func)
        width8 <= in_byte[4]; // see RULE_02
      if (is_clear || is_home)
        ac <= LCDHA_AC_RESET;
      if (is_entry)
        inc_dir <= in_byte[1];
      if (is_font)
      begin
        target <= LCDHA_MEM_FONT;
        ac <= {1'b0, in_byte[5:0]};
      end
      if (is_char)
      begin
        target <= LCDHA_MEM_CHAR;
        ac <= in_byte[6:0];
      end
      if (is_gfx)
      begin
        case (gstate)
          LCDHA_GS_IDLE:
          begin
            gy <= in_byte[6:0];
            gstate <= LCDHA_GS_HORZ;
          end
          LCDHA_GS_HORZ:
          begin
            gx <= in_byte[3:0];
            gstate <= LCDHA_GS_DATA;
            g_second <= 1'b0;
          end
          default:
          begin
            gy <= in_byte[6:0];
            gstate <= LCDHA_GS_HORZ;
          end
        endcase
      end
      if (in_byte == 8'h36 || in_byte == 8'h34)
        target <= in_byte[1] ? LCDHA_MEM_GFX : LCDHA_MEM_CHAR;
    end
    else if (mem_access && !busy)
    begin
      dr <= rd_dat ? rd_byte : in_byte; // see RULE_05
      if (target == LCDHA_MEM_GFX)
      begin
        g_second <= !g_second;
        if (g_second)
          gx <= (gx == LCDHA_GX_LAST) ? 4'h0 : gx + 4'h1; // see RULE_22
      end
      else
        ac <= inc_dir ? ac + 7'd1 : ac - 7'd1; // see RULE_13
    end
  end

  // Character memory: words kept as two bytes, upper then lower
  logic [7:0] rd_byte;
  logic [6:0] mem_addr;
  assign mem_addr = ac;
  lcdha_mem #(.ADDR_W(LCDHA_ADDR_W), .DATA_W(8)) char_mem (
    .clock_in(clock_in),
    .we_in(wr_dat && !busy && target == LCDHA_MEM_CHAR),
    .waddr_in(mem_addr),
    .wdata_in(in_byte),
    .raddr_in(mem_addr),
    .rdata_out(rd_byte)
  );

  // Decode of the last word written; start must sit on an even byte
  logic [7:0] up_byte;
  logic [15:0] code;
  logic [1:0] kind;
  wire word_end = wr_dat && !busy && target == LCDHA_MEM_CHAR && ac[0];
  wire word_start = wr_dat && !busy && target == LCDHA_MEM_CHAR && !ac[0];
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
    begin
      up_byte <= 8'h00;
      code <= 16'h0000;
      kind <= LCDHA_KIND_NONE;
    end
    else if (word_start)
      up_byte <= in_byte; // see RULE_18
    else if (word_end)
    begin
      code <= {up_byte, in_byte};
      kind <= classify({up_byte, in_byte}); // see RULE_19
    end
  end

  // Read answer: only in parallel mode, while enable is high
  wire drive = par && en && rw; // see RULE_07
  always_ff @(posedge clock_in)
  begin
    if (!nrst_in)
      db_out <= 8'h00;
    else if (!rs)
      db_out <= {busy, ac}; // see RULE_04 see RULE_14
    else
      db_out <= rd_byte;
  end
  assign db_oe_out = drive;
  assign busy_flag_out = busy;
  assign address_counter_out = ac;
  assign bus_width_bit_out = width8;
  assign instruction_register_out = ir;
  assign data_register_out = dr;
  assign char_kind_out = kind;
  assign char_code_out = code;
  assign graphic_horz_out = gx;
  assign graphic_vert_out = gy;
  assign shown_lines_out = LCDHA_SHOWN_LINES; // see RULE_20
endmodule // lcdha_core

// *** lcdha_props.sv ***
`timescale 1ns/1ps
module lcdha_props
  import lcdha_pkg::*;
#(
  parameter int EXEC_CYC = LCDHA_EXEC_CYC,
  parameter int CLEAR_CYC = LCDHA_CLEAR_CYC
)
(
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic bus_type_select_in,
  input wire logic register_select_in,
  input wire logic [7:0] db_out,
  input wire logic db_oe_out,
  input wire logic busy_flag_out,
  input wire logic [6:0] address_counter_out,
  input wire logic bus_width_bit_out,
  input wire logic [7:0] instruction_register_out,
  input wire logic [7:0] data_register_out,
  input wire logic [3:0] graphic_horz_out,
  input wire logic [6:0] graphic_vert_out,
  input wire logic [1:0] shown_lines_out
);
  default clocking @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);
  int unsigned busy_run;
  always_ff @(posedge clock_in)
    busy_run <= (!nrst_in || !busy_flag_out) ? 0 : busy_run + 1;
  sequence busy_start;
    !busy_flag_out ##1 busy_flag_out;
  endsequence
  sequence status_read;
    db_oe_out && !register_select_in;
  endsequence
  reset_vals_a: assert property (disable iff (1'b0) !nrst_in [*2] |->
    bus_width_bit_out && !busy_flag_out && address_counter_out == LCDHA_AC_RESET)
    else $error("outputs not at reset values");
  shown_two_a: assert property (shown_lines_out == LCDHA_SHOWN_LINES)
    else $error("shown line count wrong");
  serial_no_read_a: assert property (!bus_type_select_in [*4] |-> !db_oe_out)
    else $error("bus driven in serial mode");
  busy_hold_a: assert property (busy_start |=> busy_flag_out [*7])
    else $error("busy dropped early");
  busy_len_a: assert property (busy_run <= CLEAR_CYC + 2)
    else $error("busy too long");
  busy_min_a: assert property ($fell(busy_flag_out) |-> $past(busy_run) + 2 >= EXEC_CYC)
    else $error("busy too short");
  ins_idle_a: assert property ($changed(instruction_register_out) |-> !$past(busy_flag_out))
    else $error("instruction taken while busy");
  data_idle_a: assert property ($changed(data_register_out) |-> !$past(busy_flag_out))
    else $error("data taken while busy");
  gx_wrap_a: assert property ($past(graphic_horz_out) == LCDHA_GX_LAST &&
    graphic_horz_out == 4'h0 |-> $stable(graphic_vert_out))
    else $error("vertical moved on wrap");
  status_ac_a: assert property (status_read [*3] |-> db_out[6:0] == address_counter_out)
    else $error("status lines wrong");
endmodule // lcdha_props
bind lcdha_core lcdha_props #(.EXEC_CYC(EXEC_CYC), .CLEAR_CYC(CLEAR_CYC)) props (
  .clock_in(clock_in), .nrst_in(nrst_in), .bus_type_select_in(bus_type_select_in),
  .register_select_in(register_select_in), .db_out(db_out), .db_oe_out(db_oe_out),
  .busy_flag_out(busy_flag_out), .address_counter_out(address_counter_out),
  .bus_width_bit_out(bus_width_bit_out), .instruction_register_out(instruction_register_out),
  .data_register_out(data_register_out), .graphic_horz_out(graphic_horz_out),
  .graphic_vert_out(graphic_vert_out), .shown_lines_out(shown_lines_out));

// *** lcdha_host.sv ***
`timescale 1ns/1ps
module lcdha_host
(
  input wire logic clock_in,
  input wire logic busy_flag_in,
  input wire logic [7:0] db_in,
  input wire logic db_oe_in,
  output logic bus_type_select_out,
  output logic register_select_out,
  output logic rw_serial_data_out,
  output logic enable_serial_clock_out,
  output logic [7:0] db_out
);
  initial
  begin
    bus_type_select_out = 1'b1;
    register_select_out = 1'b0;
    rw_serial_data_out = 1'b0;
    enable_serial_clock_out = 1'b0;
    db_out = 8'h00;
  end
  task automatic sel(input logic par);
    @(posedge clock_in);
    bus_type_select_out <= par;
    repeat (8) @(posedge clock_in);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    repeat (6) @(posedge clock_in);
    while (busy_flag_in !== 1'b0 && n < 200)
    begin
      @(posedge clock_in);
      n++;
    end
  endtask
  task automatic strobe(input logic rs, input logic [7:0] d);
    @(posedge clock_in);
    register_select_out <= rs;
    rw_serial_data_out <= 1'b0;
    db_out <= d;
    enable_serial_clock_out <= 1'b1;
    repeat (4) @(posedge clock_in);
    enable_serial_clock_out <= 1'b0;
    repeat (6) @(posedge clock_in);
    // Past hold time the lines no longer show the last value
    db_out <= ~d;
  endtask
  task automatic par_wr(input logic rs, input logic [7:0] b, input logic nib);
    if (nib)
    begin
      strobe(rs, {b[7:4], 4'h0});
      strobe(rs, {b[3:0], 4'h0});
    end
    else
      strobe(rs, b);
    wait_idle();
  endtask
  task automatic par_rd(input logic rs, output logic [7:0] q, output logic o);
    @(posedge clock_in);
    register_select_out <= rs;
    rw_serial_data_out <= 1'b1;
    enable_serial_clock_out <= 1'b1;
    repeat (6) @(posedge clock_in);
    q = db_in;
    o = db_oe_in;
    enable_serial_clock_out <= 1'b0;
    repeat (6) @(posedge clock_in);
  endtask
  task automatic ser_wr(input logic rs, input logic [7:0] b);
    logic [23:0] f;
    f = {rs, 7'h78, b[7:4], 4'h0, b[3:0], 4'h0};
    @(posedge clock_in);
    register_select_out <= 1'b1;
    for (int i = 23; i >= 0; i--)
    begin
      rw_serial_data_out <= f[i];
      repeat (16) @(posedge clock_in);
      enable_serial_clock_out <= 1'b1;
      repeat (16) @(posedge clock_in);
      enable_serial_clock_out <= 1'b0;
    end
    repeat (8) @(posedge clock_in);
    register_select_out <= 1'b0;
    wait_idle();
  endtask
endmodule // lcdha_host

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top import lcdha_pkg::*;;
  logic clock_in, nrst_in, bts, rs, rw, en, oe, busy, width, o;
  logic [7:0] db, dq, ir, dr, q;
  logic [6:0] ac, gv;
  logic [1:0] kind, shown;
  logic [15:0] code;
  logic [3:0] gx;
  int mismatches, n_compared, cycles;
  lcdha_core #(.EXEC_CYC(20), .CLEAR_CYC(40)) dut (.clock_in(clock_in), .nrst_in(nrst_in),
    .bus_type_select_in(bts), .register_select_in(rs), .rw_serial_data_in(rw),
    .enable_serial_clock_in(en), .db_in(db), .db_out(dq), .db_oe_out(oe),
    .busy_flag_out(busy), .address_counter_out(ac), .bus_width_bit_out(width),
    .instruction_register_out(ir), .data_register_out(dr), .char_kind_out(kind),
    .char_code_out(code), .graphic_horz_out(gx), .graphic_vert_out(gv),
    .shown_lines_out(shown));
  lcdha_host host (.clock_in(clock_in), .busy_flag_in(busy), .db_in(dq), .db_oe_in(oe),
    .bus_type_select_out(bts), .register_select_out(rs), .rw_serial_data_out(rw),
    .enable_serial_clock_out(en), .db_out(db));
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want)
    begin
      mismatches++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    clock_in = 1'b0;
    forever #2.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic t_ins();
    host.strobe(1'b0, 8'h84);
    check(busy, 1'b1);
    // Second instruction lands while busy and must be dropped
    host.strobe(1'b0, 8'h9a);
    host.wait_idle();
    check(ir, 8'h84);
    check(ac, 7'h04);
    host.par_rd(1'b0, q, o);
    check({o, q}, 9'h104);
  endtask
  task automatic t_data();
    logic [15:0] w [3] = '{16'ha440, 16'h0002, 16'h4142};
    logic [1:0] k [3] = '{LCDHA_KIND_FULL, LCDHA_KIND_USER, LCDHA_KIND_HALF};
    for (int i = 0; i < 3; i++)
    begin
      host.par_wr(1'b1, w[i][15:8], 1'b0);
      check(dr, w[i][15:8]);
      check(ac, 7'h05 + 7'(2 * i));
      host.par_wr(1'b1, w[i][7:0], 1'b0);
      check(kind, k[i]);
      check(code, w[i]);
    end
    host.par_wr(1'b0, 8'h84, 1'b0);
    host.par_rd(1'b1, q, o);
    check({o, q}, 9'h1a4);
    host.wait_idle();
    check({dr, 1'b0, ac}, 16'ha405);
  endtask
  task automatic t_width();
    host.par_wr(1'b0, 8'h20, 1'b0);
    check(width, 1'b0);
    host.par_wr(1'b0, 8'h38, 1'b1);
    check({width, ir}, 9'h138);
  endtask
  task automatic t_serial();
    host.sel(1'b0);
    host.ser_wr(1'b0, 8'h8a);
    check({ir, 1'b0, ac}, 16'h8a0a);
    host.ser_wr(1'b1, 8'h41);
    check({dr, 1'b0, ac}, 16'h410b);
    check(oe, 1'b0);
    host.sel(1'b1);
  endtask
  task automatic t_gfx();
    host.par_wr(1'b0, 8'h36, 1'b0);
    host.par_wr(1'b0, 8'h83, 1'b0);
    host.par_wr(1'b0, 8'h8f, 1'b0);
    check({gv, gx}, 11'h03f);
    host.par_wr(1'b1, 8'h5a, 1'b0);
    host.par_wr(1'b1, 8'ha5, 1'b0);
    check({gv, gx}, 11'h030);
  endtask
  initial
  begin
    nrst_in = 1'b0;
    repeat (16) @(posedge clock_in);
    check({width, busy, ac, shown}, 11'h402);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    t_ins();
    t_data();
    t_width();
    t_serial();
    t_gfx();
    nrst_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    check({width, busy, ac, gv}, 16'h8000);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    host.par_wr(1'b0, 8'h90, 1'b0);
    check({ir, 1'b0, ac}, 16'h9010);
    give_verdict();
  end
endmodule // tb_top
